// >>> logic/ckg_ctrl.v
// clock generator control: configuration bytes, power-good/power-down and cpu halt
//
// Behaviour
// (R01) cpu loop uses programmed n and m dividers when its enable is set
// (R02) shared loop uses its own programmed n and m when enabled
// (R03) control byte bit 5 enables cpu loop, bit 4 shared loop; reset zero
// (R04) bits 3..0 pick disabled drive: 1 both low, 0 true high
// (R05) pin is active-low power good at start, then power-down request
// (R06) power-down is synchronised to stop, taken asynchronously to wake
// (R07) clocks are held at a fixed level before oscillators turn off
// (R08) two complement rises with request high hold outputs high
// (R09) platform raises power-down within 10 us of power good if wanted
// (R10) stable clocks within 1.8 ms of power-down release or power up
// (R11) tri-stated differential outputs driven high within 300 us of release
// (R12) after lock every output enables within a few of its cycles
// (R13) halt input stops only cpu outputs, others keep running
// (R14) halt seen on two complement rises stops cpu within 2..6 periods
// (R15) stopped cpu outputs rest true high, complement low
// (R16) cpu outputs resume on whole periods without runt or stretched pulses
// (R17) halt release to running cpu outputs within two cpu cycles
// (R18) output-enable disabled groups follow their drive-state bits
// (R19) reserved control bits 7 and 6 ignore writes and read zero
`timescale 1ns/100ps
`include "ckg_defines.vh"
module ckg_ctrl
#(
   parameter [15:0] LOCK_CYCLES = `CKG_PU_LATENCY_CYC - 16'h0010,
   parameter [7:0] CPU_HALF = 8'h02,
   parameter [7:0] PCIE_HALF = 8'h03,
   parameter [7:0] PANEL_HALF = 8'h04,
   parameter [7:0] VIDEO_HALF = 8'h05,
   parameter [7:0] REF_HALF = 8'h07,
   parameter [7:0] CPU_N_DEFAULT = 8'h00,
   parameter [7:0] CPU_M_DEFAULT = 8'h00,
   parameter [7:0] SHARED_N_DEFAULT = 8'h00,
   parameter [7:0] SHARED_M_DEFAULT = 8'h00
)
(
   input wire mclk_i,
   input wire rst_b_i,
   input wire [7:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   output wire [7:0] reg_rdata_o,
   input wire powergood_powerdown_pin_i,
   input wire cpu_clock_halt_n_i,
   input wire cpu_stoppable_i,
   input wire [3:0] group_oe_n_i,
   output wire cpu_clock_true_o,
   output wire cpu_clock_complement_o,
   output wire cpu_clock_oe_o,
   output wire pcie_clock_true_o,
   output wire pcie_clock_complement_o,
   output wire pcie_clock_oe_o,
   output wire panel_clock_true_o,
   output wire panel_clock_complement_o,
   output wire panel_clock_oe_o,
   output wire video_clock_true_o,
   output wire video_clock_complement_o,
   output wire video_clock_oe_o,
   output wire ref_clock_o,
   output wire osc_enable_o,
   output wire pin_is_power_down_o,
   output wire clocks_stable_o,
   output wire cpu_loop_prog_enable_o,
   output wire shared_loop_prog_enable_o,
   output wire [7:0] cpu_loop_n_value_o,
   output wire [7:0] cpu_loop_m_value_o,
   output wire [7:0] shared_loop_n_value_o,
   output wire [7:0] shared_loop_m_value_o
);
   // ***************************************************
   // power sequencer states
   // ***************************************************
   localparam [2:0] ST_INIT = 3'b000;
   localparam [2:0] ST_WAKE = 3'b001;
   localparam [2:0] ST_RUN = 3'b010;
   localparam [2:0] ST_PD_HOLD = 3'b011;
   localparam [2:0] ST_PD_OFF = 3'b100;

   reg [7:0] cpu_n_q;
   reg [7:0] cpu_m_q;
   reg [7:0] ctrl_q;
   reg [7:0] shared_n_q;
   reg [7:0] shared_m_q;
   reg [7:0] rdata_q;
   reg [7:0] rdata_d;
   reg [7:0] cpu_n_out_q;
   reg [7:0] cpu_m_out_q;
   reg [7:0] shared_n_out_q;
   reg [7:0] shared_m_out_q;
   reg [2:0] state_q;
   reg [2:0] state_d;
   reg [15:0] wake_cnt_q;
   reg [7:0] hold_cnt_q;
   reg [2:0] pd_edges_q;
   reg [2:0] halt_edges_q;
   reg cpu_halted_q;
   wire pin_s;
   wire halt_n_s;
   wire [3:0] oe_n_s;
   wire cpu_clock_complement_rise;
   wire hold_all;
   wire tri_all;
   wire cpu_run;
   wire pd_req;

   // ***************************************************
   // pin synchronisers
   // ***************************************************
   ckg_sync3 u_sync_pin
   (
      .mclk_i(mclk_i), .rst_b_i(rst_b_i), .pin_i(powergood_powerdown_pin_i), .rst_val_i(1'b1),
      .level_o(pin_s)
   );

   ckg_sync3 u_sync_halt
   (
      .mclk_i(mclk_i), .rst_b_i(rst_b_i), .pin_i(cpu_clock_halt_n_i), .rst_val_i(1'b1), .level_o(halt_n_s)
   );

   // enables default to disabled until the pins have been seen
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1)
      begin : g_oe_sync
         ckg_sync3 u_sync_oe
         (
            .mclk_i(mclk_i), .rst_b_i(rst_b_i), .pin_i(group_oe_n_i[gi]), .rst_val_i(1'b1), .level_o(oe_n_s[gi])
         );
      end
   endgenerate

   // ***************************************************
   // configuration bytes
   // ***************************************************
   // plain byte port: one write strobe, one read strobe, registered read data
   always @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         cpu_n_q <= `CKG_RST_CPU_N;
         cpu_m_q <= `CKG_RST_CPU_M;
         ctrl_q <= `CKG_RST_LOOP_CTRL;
         shared_n_q <= `CKG_RST_SHARED_N;
         shared_m_q <= `CKG_RST_SHARED_M;
      end
      else if (reg_wr_i)
      begin
         case (reg_addr_i)
            `CKG_ADDR_CPU_N: cpu_n_q <= reg_wdata_i;
            `CKG_ADDR_CPU_M: cpu_m_q <= reg_wdata_i;
            `CKG_ADDR_LOOP_CTRL: ctrl_q <= reg_wdata_i & `CKG_CTRL_WMASK; // R03 R19
            `CKG_ADDR_SHARED_N: shared_n_q <= reg_wdata_i;
            `CKG_ADDR_SHARED_M: shared_m_q <= reg_wdata_i;
            default: ctrl_q <= ctrl_q; // unmapped writes dropped
         endcase
      end
   end

   // unmapped addresses read as zero
   always @*
   begin
      case (reg_addr_i)
         `CKG_ADDR_CPU_N: rdata_d = cpu_n_q;
         `CKG_ADDR_CPU_M: rdata_d = cpu_m_q;
         `CKG_ADDR_LOOP_CTRL: rdata_d = ctrl_q & `CKG_CTRL_WMASK; // R19
         `CKG_ADDR_SHARED_N: rdata_d = shared_n_q;
         `CKG_ADDR_SHARED_M: rdata_d = shared_m_q;
         default: rdata_d = 8'h00;
      endcase
   end

   always @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         rdata_q <= 8'h00;
      end
      else if (reg_rd_i)
      begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata_o = rdata_q;

   // ***************************************************
   // loop divider selection
   // ***************************************************
   // the synthesiser sees the built-in ratio until software opts in
   always @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         cpu_n_out_q <= CPU_N_DEFAULT;
         cpu_m_out_q <= CPU_M_DEFAULT;
         shared_n_out_q <= SHARED_N_DEFAULT;
         shared_m_out_q <= SHARED_M_DEFAULT;
      end
      else
      begin
         cpu_n_out_q <= ctrl_q[`CKG_BIT_CPU_PROG] ? cpu_n_q : CPU_N_DEFAULT; // R01
         cpu_m_out_q <= ctrl_q[`CKG_BIT_CPU_PROG] ? cpu_m_q : CPU_M_DEFAULT; // R01
         shared_n_out_q <= ctrl_q[`CKG_BIT_SHARED_PROG] ? shared_n_q : SHARED_N_DEFAULT; // R02
         shared_m_out_q <= ctrl_q[`CKG_BIT_SHARED_PROG] ? shared_m_q : SHARED_M_DEFAULT; // R02
      end
   end

   assign cpu_loop_prog_enable_o = ctrl_q[`CKG_BIT_CPU_PROG];
   assign shared_loop_prog_enable_o = ctrl_q[`CKG_BIT_SHARED_PROG];
   assign cpu_loop_n_value_o = cpu_n_out_q;
   assign cpu_loop_m_value_o = cpu_m_out_q;
   assign shared_loop_n_value_o = shared_n_out_q;
   assign shared_loop_m_value_o = shared_m_out_q;

   // ***************************************************
   // power sequencer
   // ***************************************************
   // in pd role a high pin requests power down
   assign pd_req = pin_s & (state_q != ST_INIT); // R05

   always @*
   begin
      state_d = state_q;
      case (state_q)
         ST_INIT:
            if (!pin_s)
               state_d = ST_WAKE; // R05
         ST_WAKE, ST_RUN:
            if (pd_edges_q == `CKG_EDGE_SAMPLES)
               state_d = ST_PD_HOLD; // R06 R08
            else if ((state_q == ST_WAKE) && (wake_cnt_q == LOCK_CYCLES))
               state_d = ST_RUN; // R10 R12
         ST_PD_HOLD:
            if (hold_cnt_q == `CKG_PD_HOLD_CYC)
               state_d = ST_PD_OFF; // R07
         ST_PD_OFF:
            if (!pd_req)
               state_d = ST_WAKE;
         default: state_d = ST_INIT;
      endcase
   end

   always @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         state_q <= ST_INIT;
         wake_cnt_q <= 16'h0000;
         hold_cnt_q <= 8'h00;
         pd_edges_q <= 3'h0;
      end
      else
      begin
         state_q <= state_d;
         // lock wait counts from entry to wake
         if (state_q != ST_WAKE)
            wake_cnt_q <= 16'h0000;
         else if (wake_cnt_q != LOCK_CYCLES)
            wake_cnt_q <= wake_cnt_q + 16'h0001;
         hold_cnt_q <= (state_q == ST_PD_HOLD) ? hold_cnt_q + 8'h01 : 8'h00;
         // consecutive complement rises with request high
         if (!pd_req)
            pd_edges_q <= 3'h0;
         else if (cpu_clock_complement_rise && (pd_edges_q != `CKG_EDGE_SAMPLES))
            pd_edges_q <= pd_edges_q + 3'h1; // R08
      end
   end

   // the wake path bypasses the synchroniser so the oscillator starts
   // without waiting on a clock that may be slow to settle
   assign osc_enable_o = (state_q != ST_PD_OFF) | ~powergood_powerdown_pin_i; // R06
   assign pin_is_power_down_o = (state_q != ST_INIT);
   assign clocks_stable_o = (state_q == ST_RUN);

   // differential pads float only while off or before power good;
   // they are driven high one cycle into wake, far inside the limit
   assign tri_all = (state_q == ST_INIT) | (state_q == ST_PD_OFF) |
                    ((state_q == ST_WAKE) && (wake_cnt_q < `CKG_DIFF_RELEASE_CYC)); // R11
   assign hold_all = (state_q == ST_WAKE) | (state_q == ST_PD_HOLD); // R07 R12

   // ***************************************************
   // cpu halt
   // ***************************************************
   // two rises to see the halt, two more before the stop request
   always @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         halt_edges_q <= 3'h0;
         cpu_halted_q <= 1'b0;
      end
      else if (halt_n_s)
      begin
         halt_edges_q <= 3'h0;
         cpu_halted_q <= 1'b0; // R17
      end
      else if (cpu_clock_complement_rise && (halt_edges_q != `CKG_HALT_STOP_EDGES))
      begin
         halt_edges_q <= halt_edges_q + 3'h1;
         cpu_halted_q <= (halt_edges_q == `CKG_HALT_STOP_EDGES - 3'h1); // R14
      end
   end

   assign cpu_run = ~(cpu_halted_q & cpu_stoppable_i); // R13

   // ***************************************************
   // output groups
   // ***************************************************
   ckg_diff_out #(.HALF(CPU_HALF)) u_cpu
   (
      .mclk_i(mclk_i), .rst_b_i(rst_b_i), .run_i(cpu_run), .hold_i(hold_all), .off_i(oe_n_s[3]), // R13 R15
      .off_low_i(ctrl_q[`CKG_BIT_CPU_OFF]), .tri_i(tri_all), .comp_rise_o(cpu_clock_complement_rise),
      .true_o(cpu_clock_true_o), .comp_o(cpu_clock_complement_o), .oe_o(cpu_clock_oe_o)
   );

   ckg_diff_out #(.HALF(PCIE_HALF)) u_pcie
   (
      .mclk_i(mclk_i), .rst_b_i(rst_b_i), .run_i(1'b1), .hold_i(hold_all), .off_i(oe_n_s[2]),
      .off_low_i(ctrl_q[`CKG_BIT_PCIE_OFF]), .tri_i(tri_all), .comp_rise_o(), // R18
      .true_o(pcie_clock_true_o), .comp_o(pcie_clock_complement_o), .oe_o(pcie_clock_oe_o)
   );

   ckg_diff_out #(.HALF(PANEL_HALF)) u_panel
   (
      .mclk_i(mclk_i), .rst_b_i(rst_b_i), .run_i(1'b1), .hold_i(hold_all), .off_i(oe_n_s[1]),
      .off_low_i(ctrl_q[`CKG_BIT_PANEL_OFF]), .tri_i(tri_all), .comp_rise_o(), // R18
      .true_o(panel_clock_true_o), .comp_o(panel_clock_complement_o), .oe_o(panel_clock_oe_o)
   );

   ckg_diff_out #(.HALF(VIDEO_HALF)) u_video
   (
      .mclk_i(mclk_i), .rst_b_i(rst_b_i), .run_i(1'b1), .hold_i(hold_all), .off_i(oe_n_s[0]),
      .off_low_i(ctrl_q[`CKG_BIT_VIDEO_OFF]), .tri_i(tri_all), .comp_rise_o(), // R18
      .true_o(video_clock_true_o), .comp_o(video_clock_complement_o), .oe_o(video_clock_oe_o)
   );

   // single-ended reference: stopping lets it rise and stay high
   ckg_diff_out #(.HALF(REF_HALF)) u_ref
   (
      .mclk_i(mclk_i), .rst_b_i(rst_b_i), .run_i(state_q == ST_RUN), .hold_i(1'b0), .off_i(1'b0), // R08
      .off_low_i(1'b0), .tri_i(state_q == ST_INIT), .comp_rise_o(), .true_o(ref_clock_o), .comp_o(), .oe_o()
   );
endmodule // ckg_ctrl

// >>> logic/ckg_defines.vh
// constants of the clock generator control block
`ifndef CKG_DEFINES_VH
`define CKG_DEFINES_VH

// ***************************************************
// configuration byte offsets
// ***************************************************
`define CKG_ADDR_CPU_N      8'h11
`define CKG_ADDR_CPU_M      8'h12
`define CKG_ADDR_LOOP_CTRL  8'h13
`define CKG_ADDR_SHARED_N   8'h14
`define CKG_ADDR_SHARED_M   8'h15

// ***************************************************
// fields of loop_enable_and_drive_state
// ***************************************************
`define CKG_BIT_CPU_PROG    5
`define CKG_BIT_SHARED_PROG 4
`define CKG_BIT_CPU_OFF     3
`define CKG_BIT_PCIE_OFF    2
`define CKG_BIT_PANEL_OFF   1
`define CKG_BIT_VIDEO_OFF   0
`define CKG_CTRL_WMASK      8'h3F

// ***************************************************
// reset values
// ***************************************************
`define CKG_RST_CPU_N       8'h00
`define CKG_RST_CPU_M       8'h00
`define CKG_RST_LOOP_CTRL   8'h00
`define CKG_RST_SHARED_N    8'h00
`define CKG_RST_SHARED_M    8'h00

// ***************************************************
// timing
// ***************************************************
`define CKG_CLK_KHZ         10000
`define CKG_PU_LATENCY_US   1800
`define CKG_PU_LATENCY_CYC  ((`CKG_PU_LATENCY_US * `CKG_CLK_KHZ) / 1000)
`define CKG_DRV_HIGH_US     300
`define CKG_DRV_HIGH_CYC    ((`CKG_DRV_HIGH_US * `CKG_CLK_KHZ) / 1000)
`define CKG_DIFF_RELEASE_CYC 16'h0001
`define CKG_PD_HOLD_CYC     8'h10
`define CKG_EDGE_SAMPLES    3'h2
`define CKG_HALT_STOP_EDGES 3'h4

`endif

// >>> logic/ckg_sync3.v
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module ckg_sync3
(
   input wire mclk_i,
   input wire rst_b_i,
   input wire pin_i,
   input wire [0:0] rst_val_i,
   output wire level_o
);
   reg s1_q;
   reg s2_q;
   reg s3_q;
   reg level_q;

   // ***************************************************
   // synchroniser chain
   // ***************************************************
   // only s2 reads s1; the filter looks at the later two stages
   always @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         s1_q <= rst_val_i[0];
         s2_q <= rst_val_i[0];
         s3_q <= rst_val_i[0];
         level_q <= rst_val_i[0];
      end
      else
      begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q)
         begin
            level_q <= s3_q;
         end
      end
   end

   // whole chain resets to the idle level, so no false edge follows reset
   assign level_o = level_q;
endmodule // ckg_sync3

// >>> logic/ckg_diff_out.v
// one output clock group: divider, stop control and drive-state mux
`timescale 1ns/100ps
module ckg_diff_out
#(
   parameter [7:0] HALF = 8'h02
)
(
   input wire mclk_i,
   input wire rst_b_i,
   input wire run_i,
   input wire hold_i,
   input wire off_i,
   input wire off_low_i,
   input wire tri_i,
   output wire comp_rise_o,
   output wire true_o,
   output wire comp_o,
   output wire oe_o
);
   reg [7:0] cnt_q;
   reg phase_q;
   reg free_q;
   reg true_q;
   reg comp_q;
   reg oe_q;
   reg phase_d;
   wire tick;

   assign tick = (cnt_q == HALF - 8'h01);
   // free reference falls here: the internal complement rises
   assign comp_rise_o = tick & free_q;

   // ***************************************************
   // phase: stopping only lets the clock finish at true high
   // ***************************************************
   always @*
   begin
      phase_d = phase_q;
      if (tick && (run_i || !phase_q))
      begin
         phase_d = ~phase_q;
      end
   end

   // divider and phase run on their own counter, so resume starts
   // from a whole half period and never yields a runt pulse
   always @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         cnt_q <= 8'h00;
         phase_q <= 1'b0;
         free_q <= 1'b0;
      end
      else
      begin
         cnt_q <= tick ? 8'h00 : cnt_q + 8'h01;
         phase_q <= phase_d; // R16
         if (tick)
         begin
            free_q <= ~free_q;
         end
      end
   end

   // ***************************************************
   // pad drive
   // ***************************************************
   always @(posedge mclk_i)
   begin
      if (!rst_b_i)
      begin
         true_q <= 1'b0;
         comp_q <= 1'b0;
         oe_q <= 1'b0;
      end
      else if (tri_i)
      begin
         true_q <= 1'b0;
         comp_q <= 1'b0;
         oe_q <= 1'b0;
      end
      else if (hold_i)
      begin
         true_q <= 1'b1; // R08
         comp_q <= 1'b0;
         oe_q <= 1'b1;
      end
      else if (off_i)
      begin
         true_q <= ~off_low_i; // R04 R18
         comp_q <= 1'b0;
         oe_q <= 1'b1;
      end
      else
      begin
         true_q <= phase_d; // R15
         comp_q <= ~phase_d;
         oe_q <= 1'b1;
      end
   end

   assign true_o = true_q;
   assign comp_o = comp_q;
   assign oe_o = oe_q;
endmodule // ckg_diff_out

// >>> verif/ckg_ctrl_sva.sv
// port assertions of the clock generator control block
`timescale 1ns/100ps
module ckg_ctrl_sva
(
   input wire mclk_i,
   input wire rst_b_i,
   input wire [7:0] reg_addr_i,
   input wire [7:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   input wire [7:0] reg_rdata_o,
   input wire powergood_powerdown_pin_i,
   input wire cpu_clock_halt_n_i,
   input wire cpu_stoppable_i,
   input wire [3:0] group_oe_n_i,
   input wire cpu_clock_true_o,
   input wire cpu_clock_complement_o,
   input wire pcie_clock_true_o,
   input wire osc_enable_o,
   input wire pin_is_power_down_o,
   input wire clocks_stable_o,
   input wire cpu_loop_prog_enable_o,
   input wire shared_loop_prog_enable_o,
   input wire [7:0] cpu_loop_n_value_o,
   input wire [7:0] shared_loop_n_value_o
);
   // ****
   // helper logic
   // ****
   // cycles of a held halt on running, enabled, stoppable cpu outputs; saturates
   logic [5:0] halt_q;
   always @(posedge mclk_i)
   begin
      if (!rst_b_i || cpu_clock_halt_n_i || !cpu_stoppable_i || !clocks_stable_o || group_oe_n_i[3])
         halt_q <= 6'h00;
      else if (halt_q != 6'h3F)
         halt_q <= halt_q + 6'h01;
   end
   default clocking dcb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   // ****
   // assertions
   // ****
   a_rsvd_read_zero: assert property (reg_rd_i && reg_addr_i == 8'h13 |=> reg_rdata_o[7:6] == 2'h0)
      else $error("reserved control bits read back nonzero");
   a_prog_bits_map: assert property (reg_wr_i && reg_addr_i == 8'h13 |=>
      {cpu_loop_prog_enable_o, shared_loop_prog_enable_o} == $past(reg_wdata_i[5:4]))
      else $error("loop enables do not follow control write");
   a_div_default: assert property ((!cpu_loop_prog_enable_o && !shared_loop_prog_enable_o)[*2] |->
      cpu_loop_n_value_o == 8'h00 && shared_loop_n_value_o == 8'h00)
      else $error("disabled loop does not use default divider");
   a_pg_first: assert property (!pin_is_power_down_o |-> osc_enable_o)
      else $error("oscillator off before power good");
   a_wake_async: assert property (pin_is_power_down_o && !powergood_powerdown_pin_i |-> osc_enable_o)
      else $error("oscillator not restarted at once on wake");
   a_hold_before_off: assert property ($fell(osc_enable_o) |->
      $past(cpu_clock_true_o && !cpu_clock_complement_o))
      else $error("oscillator stopped before clocks were held");
   a_halt_rest: assert property (halt_q >= 6'h28 |-> cpu_clock_true_o && !cpu_clock_complement_o)
      else $error("cpu outputs not parked after halt");
   a_halt_resume: assert property ($rose(cpu_clock_halt_n_i) && halt_q >= 6'h28 |->
      ##[1:16] !cpu_clock_true_o)
      else $error("cpu outputs late to resume");
   a_pcie_runs: assert property ((clocks_stable_o && !group_oe_n_i[2])[*8] ##1
      (clocks_stable_o && !group_oe_n_i[2])[*4] |-> pcie_clock_true_o != $past(pcie_clock_true_o, 3))
      else $error("pcie clock stopped while running");
endmodule // ckg_ctrl_sva

bind ckg_ctrl ckg_ctrl_sva u_sva (.mclk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
   .reg_rdata_o, .powergood_powerdown_pin_i, .cpu_clock_halt_n_i, .cpu_stoppable_i, .group_oe_n_i,
   .cpu_clock_true_o, .cpu_clock_complement_o, .pcie_clock_true_o, .osc_enable_o, .pin_is_power_down_o,
   .clocks_stable_o, .cpu_loop_prog_enable_o, .shared_loop_prog_enable_o, .cpu_loop_n_value_o,
   .shared_loop_n_value_o);

// >>> verif/ckg_platform.sv
// platform power management model driving the power pin and the cpu halt pin
`timescale 1ns/100ps
module ckg_platform
#(
   parameter int PG_CYC = 20
)
(
   input wire mclk_i,
   input wire good_i,
   input wire down_i,
   input wire halt_i,
   output reg pin_o = 1'b1,
   output reg halt_n_o = 1'b1
);
   // ****
   // pin sequencing
   // ****
   // power good is shown low long enough to be seen, and an initial power-down
   // follows well inside 10 us, else it would read as a late stop request
   int cnt = 0;
   always @(posedge mclk_i)
   begin
      cnt <= good_i ? (cnt < PG_CYC ? cnt + 1 : cnt) : 0;
      pin_o <= !good_i || (down_i && cnt >= PG_CYC);
      halt_n_o <= !halt_i;
   end
endmodule // ckg_platform

// >>> verif/testbench.sv
// self-checking bench of the clock generator control block
`timescale 1ns/100ps
module testbench;
   // ****
   // clock, stimulus and wiring
   // ****
   localparam logic [15:0] LOCK = 16'h0032;
   logic mclk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic good = 1'b0;
   logic down = 1'b0;
   logic halt = 1'b0;
   logic stoppable = 1'b1;
   logic [3:0] oe_n = 4'h0;
   wire pin, halt_n, osc, is_pd, stable, cpu_en, sh_en, ref_clk;
   wire [7:0] rdata, cpu_n, cpu_m, sh_n, sh_m;
   wire [3:0] tru, cmp, oe;
   int error_cnt = 0;
   int total_checks = 0;
   logic [7:0] got;
   // free-running system clock, 100 ns period
   initial
   begin
      forever #50 mclk_i = ~mclk_i;
   end
   ckg_platform plat (.mclk_i(mclk_i), .good_i(good), .down_i(down), .halt_i(halt), .pin_o(pin),
      .halt_n_o(halt_n));
   ckg_ctrl #(.LOCK_CYCLES(LOCK)) dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .powergood_powerdown_pin_i(pin), .cpu_clock_halt_n_i(halt_n), .cpu_stoppable_i(stoppable),
      .group_oe_n_i(oe_n), .cpu_clock_true_o(tru[3]), .cpu_clock_complement_o(cmp[3]),
      .cpu_clock_oe_o(oe[3]), .pcie_clock_true_o(tru[2]), .pcie_clock_complement_o(cmp[2]),
      .pcie_clock_oe_o(oe[2]), .panel_clock_true_o(tru[1]), .panel_clock_complement_o(cmp[1]),
      .panel_clock_oe_o(oe[1]), .video_clock_true_o(tru[0]), .video_clock_complement_o(cmp[0]),
      .video_clock_oe_o(oe[0]), .ref_clock_o(ref_clk), .osc_enable_o(osc), .pin_is_power_down_o(is_pd),
      .clocks_stable_o(stable), .cpu_loop_prog_enable_o(cpu_en), .shared_loop_prog_enable_o(sh_en),
      .cpu_loop_n_value_o(cpu_n), .cpu_loop_m_value_o(cpu_m), .shared_loop_n_value_o(sh_n),
      .shared_loop_m_value_o(sh_m));
   // ****
   // shared tasks
   // ****
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] act, input logic [7:0] exp);
      total_checks++;
      if (act !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, act, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk_i);
      wr <= 1'b0;
   endtask
   // read data is registered, so it is taken just after the edge that accepted the strobe
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk_i);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   function automatic logic hit(input int sel);
      case (sel)
         0: return stable === 1'b1;
         1: return osc === 1'b0;
         2: return tru[3] === 1'b0;
         default: return stable === 1'b0;
      endcase
   endfunction
   // waits on settled values at the falling edge; a spent bound ends the run
   task automatic wait_on(input int sel, input int lim);
      int n = 0;
      while (n < lim && !hit(sel))
      begin
         @(negedge mclk_i);
         n++;
      end
      if (n >= lim)
      begin
         error_cnt++;
         $display("mismatch at %0t: wait %h got %h", $time, sel, n);
         tally_and_finish();
      end
   endtask
   // ****
   // scenarios
   // ****
   task automatic t_regs();
      for (logic [7:0] a = 8'h10; a < 8'h17; a++)
      begin
         rd_reg(a, got);
         chk(got, 8'h00);
         wr_reg(a, a == 8'h13 ? 8'hFF : a + 8'h80);
      end
      for (logic [7:0] a = 8'h10; a < 8'h17; a++)
      begin
         rd_reg(a, got);
         chk(got, a == 8'h13 ? 8'h3F : (a < 8'h11 || a > 8'h15) ? 8'h00 : a + 8'h80);
      end
      chk({6'h00, cpu_en, sh_en}, 8'h03);
      chk(cpu_n, 8'h91);
      chk(cpu_m, 8'h92);
      chk(sh_n, 8'h94);
      chk(sh_m, 8'h95);
      wr_reg(8'h13, 8'h20);
      repeat (3) @(negedge mclk_i);
      chk(cpu_n, 8'h91);
      chk(sh_m, 8'h00);
      wr_reg(8'h13, 8'h00);
      $display("t_regs done");
   endtask
   task automatic t_power_up();
      repeat (20) @(negedge mclk_i);
      chk({5'h00, osc, is_pd, stable}, 8'h04);
      @(posedge mclk_i);
      good <= 1'b1;
      wait_on(0, 110);
      chk({7'h00, is_pd}, 8'h01);
      repeat (4) @(negedge mclk_i);
      chk({4'h0, oe}, 8'h0F);
      $display("t_power_up done");
   endtask
   task automatic t_off_state();
      for (logic [4:0] v = 5'h05; v < 5'h10; v = v + 5'h05)
      begin
         wr_reg(8'h13, {4'h0, v[3:0]});
         oe_n <= 4'hF;
         repeat (10) @(negedge mclk_i);
         chk({tru, cmp}, {~v[3:0], 4'h0});
         @(posedge mclk_i);
         oe_n <= 4'h0;
      end
      wr_reg(8'h13, 8'h00);
      repeat (16) @(negedge mclk_i);
      $display("t_off_state done");
   endtask
   task automatic t_halt();
      @(posedge mclk_i);
      stoppable <= 1'b0;
      halt <= 1'b1;
      repeat (40) @(negedge mclk_i);
      got = {7'h00, tru[3]};
      repeat (2) @(negedge mclk_i);
      chk({7'h00, tru[3]}, ~got & 8'h01);
      @(posedge mclk_i);
      stoppable <= 1'b1;
      repeat (40) @(negedge mclk_i);
      chk({6'h00, tru[3], cmp[3]}, 8'h02);
      got = {7'h00, tru[2]};
      repeat (3) @(negedge mclk_i);
      chk({7'h00, tru[2]}, ~got & 8'h01);
      @(posedge mclk_i);
      halt <= 1'b0;
      wait_on(2, 16);
      @(negedge mclk_i);
      got = {7'h00, tru[3]};
      @(negedge mclk_i);
      chk({got[0], tru[3]}, 8'h01);
      $display("t_halt done");
   endtask
   task automatic t_power_down();
      @(posedge mclk_i);
      down <= 1'b1;
      wait_on(3, 40);
      repeat (2) @(negedge mclk_i);
      chk({tru, cmp}, 8'hF0);
      wait_on(1, 40);
      // pad enables are registered, one cycle behind the oscillator stop
      @(negedge mclk_i);
      chk({3'h0, ref_clk, oe}, 8'h10);
      @(posedge mclk_i);
      down <= 1'b0;
      @(negedge mclk_i);
      @(negedge mclk_i);
      chk({7'h00, osc}, 8'h01);
      wait_on(0, 110);
      chk({4'h0, oe}, 8'h0F);
      $display("t_power_down done");
   endtask
   // ****
   // main sequence
   // ****
   initial
   begin
      repeat (12) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      t_regs();
      t_power_up();
      t_off_state();
      t_halt();
      t_power_down();
      tally_and_finish();
   end
endmodule // testbench
